// ### pllrc_pkg.sv
// constants for the pll reconfiguration and phase-step block
package pllrc_pkg;
   // =====================================================================
   // scan chain layout
   localparam int CHAIN_BITS = 144;
   localparam int GROUP_BITS = 18;
   localparam int GROUPS = 7;
   localparam int COUNT_BITS = 8;
   localparam int LOW_LSB = 0;
   localparam int ODD_BIT = 8;
   localparam int HIGH_LSB = 9;
   localparam int BYPASS_BIT = 17;
   localparam int PUMP_LSB = 126;
   localparam int FILTER_LSB = 135;
   localparam int FIELD9 = 9;
   localparam int RES_LSB = 0;
   localparam int CAP_LSB = 5;
   localparam int TAP_BITS = 3;
   localparam int TAP_COUNTERS = 6;
   localparam int FB_INDEX = 5;
   localparam logic [7:0] CHAIN_COUNT = 8'h90;
   // =====================================================================
   // counter select codes
   localparam logic [2:0] SEL_ALL = 3'h0;
   localparam logic [2:0] SEL_FB = 3'h1;
   localparam logic [2:0] SEL_C0 = 3'h2;
   localparam logic [2:0] SEL_C4 = 3'h6;
   // =====================================================================
   // register map (byte addresses)
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_STATUS = 8'h04;
   localparam logic [7:0] ADDR_TAPS = 8'h08;
   localparam logic [7:0] ADDR_LOOP = 8'h0C;
   localparam logic [7:0] ADDR_CNT0 = 8'h10;
   localparam logic [7:0] ADDR_CNT6 = 8'h28;
   // ctrl fields and reset values
   localparam int CTRL_PHASE_LSB = 0;
   localparam int CTRL_UPD_LSB = 8;
   localparam logic [7:0] PHASE_BUSY_RESET = 8'h10;
   localparam logic [7:0] UPD_BUSY_RESET = 8'h20;
   // status fields
   localparam int ST_PHASE_DONE = 0;
   localparam int ST_SCAN_DONE = 1;
   localparam int ST_CODE_ERR = 2;
   localparam int ST_SHORT_ERR = 3;
   localparam int ST_COUNT_LSB = 8;
   // active counters come up bypassed
   localparam logic [17:0] CNT_RESET = 18'h20000;
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   // =====================================================================
   typedef enum logic [1:0] {
      PS_IDLE = 2'b00,
      PS_WAIT = 2'b01,
      PS_SHIFT = 2'b10,
      PS_REARM = 2'b11
   } pllrc_phase_e;
endpackage : pllrc_pkg

// ### pllrc_top.sv
// pll reconfiguration scan chain and dynamic phase-step controller
`timescale 1ns/1ps
module pllrc_top (
   input wire logic hclk, // system clock, 200 MHz
   input wire logic hresetn, // asynchronous reset, active low
   input wire logic hsel, // ahb slave select
   input wire logic [31:0] haddr, // ahb address
   input wire logic [1:0] htrans, // ahb transfer type
   input wire logic hwrite, // ahb write
   input wire logic [2:0] hsize, // ahb size
   input wire logic [31:0] hwdata, // ahb write data
   input wire logic hready, // ahb bus ready
   output logic hreadyout, // ahb slave ready
   output logic hresp, // ahb response, always okay
   output logic [31:0] hrdata, // ahb read data
   input wire logic scan_clk, // free-running scan clock from core
   input wire logic scan_clk_ena, // scan shift enable
   input wire logic scan_data, // serial scan data
   input wire logic config_update, // load scanned settings
   output logic scan_done, // high while settings are applied
   input wire logic phase_step, // phase step request
   input wire logic phase_up_down, // step direction, 1 up
   input wire logic [2:0] phase_counter_select, // counters to step
   output logic phase_done, // low while a step is in progress
   output logic [17:0] phase_taps // tap selection, 3 bits per counter
);
   // =====================================================================
   // synchronisers: every core-side scan and phase-step pin passes two flops
   logic [7:0] pin_meta;
   logic [7:0] pin_sync;
   logic clk_prev;
   logic sclk_meta;
   logic sclk_s;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pin_meta <= 8'h00;
         pin_sync <= 8'h00;
         clk_prev <= 1'b0;
      end else begin
         pin_meta <= {phase_counter_select, phase_up_down, phase_step,
                      config_update, scan_data, scan_clk_ena};
         pin_sync <= pin_meta;
         clk_prev <= sclk_s;
      end
   end
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sclk_meta <= 1'b0;
         sclk_s <= 1'b0;
      end else begin
         sclk_meta <= scan_clk;
         sclk_s <= sclk_meta;
      end
   end
   // data and clock share the same delay, so their skew is preserved
   logic ena_s;
   logic data_s;
   logic upd_s;
   logic step_s;
   logic dir_s;
   logic [2:0] sel_s;
   logic sclk_rise;
   logic sclk_fall;
   assign ena_s = pin_sync[0];
   assign data_s = pin_sync[1];
   assign upd_s = pin_sync[2];
   assign step_s = pin_sync[3];
   assign dir_s = pin_sync[4];
   assign sel_s = pin_sync[7:5];
   assign sclk_rise = sclk_s & ~clk_prev;
   assign sclk_fall = ~sclk_s & clk_prev;

   // =====================================================================
   // software control
   logic [7:0] phase_busy;
   logic [7:0] upd_busy;
   logic code_err;
   logic short_err;
   logic wr_pend;
   logic [7:0] wr_addr;
   logic ahb_take;
   assign ahb_take = hsel & hready & (htrans == pllrc_pkg::HTRANS_NONSEQ);

   // =====================================================================
   // scan chain, shifted on rising scan-clock edges while enabled
   logic [pllrc_pkg::CHAIN_BITS-1:0] chain;
   logic [7:0] shift_count;
   logic ena_armed;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         chain <= '0;
         shift_count <= 8'h00;
         ena_armed <= 1'b0;
      end else if (sclk_rise && ena_s) begin
         // the first rise with enable high only arms the chain
         ena_armed <= 1'b1;
         if (ena_armed) begin
            // first bit in ends at bit 0 after a full load
            chain <= {data_s, chain[pllrc_pkg::CHAIN_BITS-1:1]};
            if (shift_count != 8'hFF) begin
               shift_count <= shift_count + 8'h01;
            end
         end
      end else if (sclk_rise) begin
         ena_armed <= 1'b0;
         if (upd_s) begin
            shift_count <= 8'h00;
         end
      end
   end

   // =====================================================================
   // field checks on the scanned pump and filter codes
   logic [2:0] scan_pump;
   logic [4:0] scan_res;
   logic [1:0] scan_cap;
   logic pump_ok;
   logic res_ok;
   logic cap_ok;
   logic [8:0] scan_pump9;
   logic [8:0] scan_filt9;
   // pump field precedes filter, filter msb is chain msb
   assign scan_pump9 = chain[pllrc_pkg::PUMP_LSB +: pllrc_pkg::FIELD9];
   assign scan_filt9 = chain[pllrc_pkg::FILTER_LSB +: pllrc_pkg::FIELD9];
   assign scan_pump = scan_pump9[2:0];
   assign scan_res = scan_filt9[pllrc_pkg::RES_LSB +: 5];
   assign scan_cap = scan_filt9[pllrc_pkg::CAP_LSB +: 2];
   always_comb begin
      // pump thermometer fills from the top bit down, cap from the bottom up
      unique case (scan_pump)
         3'h0, 3'h4, 3'h6, 3'h7: pump_ok = 1'b1;
         default: pump_ok = 1'b0;
      endcase
      unique case (scan_res)
         5'h00, 5'h03, 5'h04, 5'h08, 5'h10, 5'h13, 5'h14, 5'h18, 5'h1B,
         5'h1C, 5'h1E: res_ok = 1'b1;
         default: res_ok = 1'b0;
      endcase
      unique case (scan_cap)
         2'h0, 2'h1, 2'h3: cap_ok = 1'b1;
         default: cap_ok = 1'b0;
      endcase
   end

   // =====================================================================
   // update: load active settings, scan_done high while settling
   logic [pllrc_pkg::GROUPS-1:0][17:0] cfg_cnt;
   logic [8:0] cfg_pump;
   logic [8:0] cfg_filt;
   logic [7:0] upd_count;
   logic upd_go;
   logic upd_full;
   assign upd_full = (shift_count == pllrc_pkg::CHAIN_COUNT);
   assign upd_go = sclk_rise & upd_s & ~ena_s & ~scan_done;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cfg_cnt <= {pllrc_pkg::GROUPS{pllrc_pkg::CNT_RESET}};
         cfg_pump <= 9'h000;
         cfg_filt <= 9'h000;
      end else if (upd_go && upd_full) begin
         for (int g = 0; g < pllrc_pkg::GROUPS; g++) begin
            // groups run c4..c0, feedback, prescale
            cfg_cnt[(g < 5) ? 4 - g : g] <=
               chain[g*pllrc_pkg::GROUP_BITS +: pllrc_pkg::GROUP_BITS];
         end
         // an illegal code keeps the previous bandwidth setting
         if (pump_ok && res_ok && cap_ok) begin
            cfg_pump <= scan_pump9;
            cfg_filt <= scan_filt9;
         end
      end
   end
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         scan_done <= 1'b0;
         upd_count <= 8'h00;
      end else if (upd_go && upd_full) begin
         scan_done <= 1'b1;
         upd_count <= upd_busy;
      end else if (scan_done) begin
         if (upd_count == 8'h00) begin
            scan_done <= 1'b0;
         end else begin
            upd_count <= upd_count - 8'h01;
         end
      end
   end

   // =====================================================================
   // phase step handshake
   pllrc_pkg::pllrc_phase_e ps_state;
   logic rise_seen;
   logic step_dir;
   logic [2:0] step_sel;
   logic [7:0] step_count;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ps_state <= pllrc_pkg::PS_IDLE;
         rise_seen <= 1'b0;
         step_dir <= 1'b0;
         step_sel <= 3'h0;
         step_count <= 8'h00;
         phase_done <= 1'b1;
      end else begin
         unique case (ps_state)
            pllrc_pkg::PS_IDLE: begin
               if (sclk_fall && step_s) begin
                  ps_state <= pllrc_pkg::PS_WAIT;
                  rise_seen <= 1'b0;
               end
            end
            pllrc_pkg::PS_WAIT: begin
               if (sclk_rise) begin
                  rise_seen <= 1'b1;
                  if (rise_seen) begin
                     // second rising edge after the sample
                     step_dir <= dir_s;
                     step_sel <= sel_s;
                     step_count <= phase_busy;
                     phase_done <= 1'b0;
                     ps_state <= pllrc_pkg::PS_SHIFT;
                  end
               end
            end
            pllrc_pkg::PS_SHIFT: begin
               // low time set by internal timing, not by scan clock
               if (step_count == 8'h00) begin
                  phase_done <= 1'b1;
                  ps_state <= pllrc_pkg::PS_REARM;
               end else begin
                  step_count <= step_count - 8'h01;
               end
            end
            pllrc_pkg::PS_REARM: begin
               // a held request never yields a second step
               if (!step_s) begin
                  ps_state <= pllrc_pkg::PS_IDLE;
               end
            end
         endcase
      end
   end

   // tap moves happen alone; counters and outputs are never gated
   logic tap_apply;
   assign tap_apply = (ps_state == pllrc_pkg::PS_SHIFT) &&
                      (step_count == 8'h00);
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         phase_taps <= 18'h00000;
      end else if (tap_apply) begin
         for (int t = 0; t < pllrc_pkg::TAP_COUNTERS; t++) begin
            // all = c0..c4; fb; c0..c4 by code; 111 moves nothing
            if ((step_sel == pllrc_pkg::SEL_ALL && t != pllrc_pkg::FB_INDEX)
                || (step_sel == pllrc_pkg::SEL_FB
                    && t == pllrc_pkg::FB_INDEX)
                || (step_sel >= pllrc_pkg::SEL_C0
                    && step_sel <= pllrc_pkg::SEL_C4
                    && t == int'(step_sel - pllrc_pkg::SEL_C0))) begin
               // one tap of eight, wrapping
               phase_taps[t*pllrc_pkg::TAP_BITS +: pllrc_pkg::TAP_BITS] <=
                  step_dir ?
                  phase_taps[t*pllrc_pkg::TAP_BITS +: pllrc_pkg::TAP_BITS]
                     + 3'h1 :
                  phase_taps[t*pllrc_pkg::TAP_BITS +: pllrc_pkg::TAP_BITS]
                     - 3'h1;
            end
         end
      end
   end

   // =====================================================================
   // effective division: bypass msb wins, other bits ignored
   function automatic logic [9:0] eff_div(input logic [17:0] f);
      if (f[pllrc_pkg::BYPASS_BIT]) begin
         eff_div = 10'h001;
      end else begin
         // 8-bit high plus 8-bit low time
         eff_div = {2'h0, f[pllrc_pkg::HIGH_LSB +: pllrc_pkg::COUNT_BITS]}
                 + {2'h0, f[pllrc_pkg::LOW_LSB +: pllrc_pkg::COUNT_BITS]};
      end
   endfunction : eff_div

   // =====================================================================
   // ahb-lite slave, zero wait states
   logic [31:0] next_rdata;
   logic [7:0] ra;
   assign ra = haddr[7:0];
   always_comb begin
      next_rdata = 32'h00000000;
      if (ra == pllrc_pkg::ADDR_CTRL) begin
         next_rdata = {16'h0000, upd_busy, phase_busy};
      end else if (ra == pllrc_pkg::ADDR_STATUS) begin
         next_rdata = {16'h0000, shift_count, 4'h0, short_err, code_err,
                       scan_done, phase_done};
      end else if (ra == pllrc_pkg::ADDR_TAPS) begin
         next_rdata = {14'h0000, phase_taps};
      end else if (ra == pllrc_pkg::ADDR_LOOP) begin
         next_rdata = {7'h00, cfg_filt, 7'h00, cfg_pump};
      end else if (ra >= pllrc_pkg::ADDR_CNT0 && ra <= pllrc_pkg::ADDR_CNT6
                   && ra[1:0] == 2'h0) begin
         next_rdata = {4'h0, eff_div(cfg_cnt[ra[4:2] - 3'h4]),
                       cfg_cnt[ra[4:2] - 3'h4]};
      end
   end
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h00000000;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         wr_pend <= 1'b0;
         wr_addr <= 8'h00;
      end else begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         wr_pend <= ahb_take & hwrite;
         if (ahb_take) begin
            wr_addr <= ra;
         end
         if (ahb_take && !hwrite) begin
            hrdata <= next_rdata;
         end
      end
   end
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         phase_busy <= pllrc_pkg::PHASE_BUSY_RESET;
         upd_busy <= pllrc_pkg::UPD_BUSY_RESET;
      end else if (wr_pend && wr_addr == pllrc_pkg::ADDR_CTRL) begin
         phase_busy <= hwdata[pllrc_pkg::CTRL_PHASE_LSB +: 8];
         upd_busy <= hwdata[pllrc_pkg::CTRL_UPD_LSB +: 8];
      end
   end
   // error flags: write one to clear, a new error in the same cycle wins
   logic clr_st;
   assign clr_st = wr_pend && (wr_addr == pllrc_pkg::ADDR_STATUS);
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         code_err <= 1'b0;
         short_err <= 1'b0;
      end else begin
         if (upd_go && upd_full && !(pump_ok && res_ok && cap_ok)) begin
            code_err <= 1'b1;
         end else if (clr_st && hwdata[pllrc_pkg::ST_CODE_ERR]) begin
            code_err <= 1'b0;
         end
         if (upd_go && !upd_full) begin
            short_err <= 1'b1;
         end else if (clr_st && hwdata[pllrc_pkg::ST_SHORT_ERR]) begin
            short_err <= 1'b0;
         end
      end
   end
endmodule : pllrc_top

// ### pllrc_assertions.sv
// assertions on the phase-step and scan-update ports
`timescale 1ns/1ps
module pllrc_checker (
   input wire logic hclk, // system clock
   input wire logic hresetn, // reset, active low
   input wire logic scan_clk, // scan clock pin
   input wire logic scan_clk_ena, // shift enable
   input wire logic config_update, // update request
   input wire logic scan_done, // settings apply
   input wire logic phase_step, // step request
   input wire logic phase_done, // step finished
   input wire logic [17:0] phase_taps // tap selection
);
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);
   // =====================================================================
   // a step may move any tap by one position only, wrapping
   function automatic logic one_step(logic [17:0] a, logic [17:0] b);
      int i;
      logic [2:0] d;
      one_step = 1'b1;
      for (i = 0; i < 6; i++) begin
         d = a[i*3 +: 3] - b[i*3 +: 3];
         if (d != 3'h0 && d != 3'h1 && d != 3'h7) one_step = 1'b0;
      end
   endfunction : one_step
   // =====================================================================
   taps_on_done_a: assert property
      ($changed(phase_taps) |-> $rose(phase_done))
      else $error("taps moved without done rising");
   tap_step_a: assert property
      ($changed(phase_taps) |-> one_step(phase_taps, $past(phase_taps)))
      else $error("tap moved by more than one");
   select_split_a: assert property
      ($changed(phase_taps[14:0]) |-> $stable(phase_taps[17:15]))
      else $error("output and feedback taps moved together");
   done_low_a: assert property
      ($fell(phase_done) |-> ##[1:300] phase_done)
      else $error("done stayed low too long");
   done_req_a: assert property
      ($fell(phase_done) |-> phase_step)
      else $error("step started with no request");
   done_edge_a: assert property
      ($fell(phase_done) |-> scan_clk)
      else $error("done fell away from a scan clock rise");
   taps_hold_a: assert property
      (!phase_done |-> $stable(phase_taps))
      else $error("taps moved while done low");
   scan_busy_a: assert property
      ($rose(scan_done) |-> ##[1:300] !scan_done)
      else $error("scan done stayed high too long");
   scan_cause_a: assert property
      ($rose(scan_done) |-> config_update && !scan_clk_ena)
      else $error("scan done rose without an update");
endmodule : pllrc_checker

bind pllrc_top pllrc_checker pllrc_checker_inst (.hclk, .hresetn, .scan_clk,
   .scan_clk_ena, .config_update, .scan_done, .phase_step, .phase_done,
   .phase_taps);

// ### pllrc_core_model.sv
// model of the core logic on the scan link and phase-step pins
`timescale 1ns/1ps
module pllrc_core_model (
   input wire logic hclk, // bench clock
   output logic scan_clk, // scan clock
   output logic scan_clk_ena, // shift enable
   output logic scan_data, // serial data
   output logic config_update, // update request
   output logic phase_step, // step request
   output logic phase_up_down, // direction
   output logic [2:0] phase_counter_select, // counters
   input wire logic phase_done // step finished
);
   // free running, odd offset keeps it off the hclk grid
   initial begin
      scan_clk = 1'b0;
      scan_clk_ena = 1'b0;
      scan_data = 1'b0;
      config_update = 1'b0;
      phase_step = 1'b0;
      phase_up_down = 1'b0;
      phase_counter_select = 3'h0;
      #37.3;
      forever #80 scan_clk = ~scan_clk;
   end
   // =====================================================================
   // drive just after an hclk edge following a scan clock fall
   task automatic tick();
      @(negedge scan_clk);
      @(posedge hclk);
   endtask : tick
   task automatic shift_bits(input logic [143:0] b, input int n);
      int i;
      // enable leads the first bit by one scan cycle
      tick();
      scan_clk_ena <= 1'b1;
      for (i = 0; i < n; i++) begin
         tick();
         scan_data <= b[i];
      end
      tick();
      scan_clk_ena <= 1'b0;
      scan_data <= ~scan_data;
   endtask : shift_bits
   task automatic update();
      tick();
      config_update <= 1'b1;
      tick();
      config_update <= 1'b0;
   endtask : update
   task automatic phase_move(input logic up, input logic [2:0] sel);
      tick();
      phase_up_down <= up;
      phase_counter_select <= sel;
      tick();
      phase_step <= 1'b1;
      repeat (2) @(negedge scan_clk);
      // no local limit: only the bench watchdog ends a hang
      while (phase_done === 1'b1) @(posedge hclk);
      @(posedge hclk);
      phase_step <= 1'b0;
      while (phase_done !== 1'b1) @(posedge hclk);
      tick();
   endtask : phase_move
endmodule : pllrc_core_model

// ### pllrc_top_tb_top.sv
// register-level tests of the reconfiguration and phase-step block
`timescale 1ns/1ps
module pllrc_top_tb_top;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic hready, hreadyout, hresp, scan_done, phase_done;
   logic [31:0] hrdata;
   logic scan_clk, scan_clk_ena, scan_data, config_update;
   logic phase_step, phase_up_down;
   logic [2:0] phase_counter_select;
   logic [17:0] phase_taps;
   logic [17:0] bad [3] = '{18'h0E602, 18'h0E406, 18'h0A606};
   int errors = 0;
   int tests_run = 0;
   int scan_rises = 0;
   assign hready = hreadyout;
   always @(posedge scan_done) scan_rises++;
   always #2.5 hclk = ~hclk;
   pllrc_top pllrc_top_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
      .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
      .hresp(hresp), .hrdata(hrdata), .scan_clk(scan_clk),
      .scan_clk_ena(scan_clk_ena), .scan_data(scan_data),
      .config_update(config_update), .scan_done(scan_done),
      .phase_step(phase_step), .phase_up_down(phase_up_down),
      .phase_counter_select(phase_counter_select),
      .phase_done(phase_done), .phase_taps(phase_taps));
   pllrc_core_model m (.hclk(hclk), .scan_clk(scan_clk),
      .scan_clk_ena(scan_clk_ena), .scan_data(scan_data),
      .config_update(config_update), .phase_step(phase_step),
      .phase_up_down(phase_up_down),
      .phase_counter_select(phase_counter_select),
      .phase_done(phase_done));
   // =====================================================================
   task automatic finish_test();
      if (errors == 0 && tests_run > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : finish_test
   task automatic check(input string what, input logic [31:0] seen, exp);
      tests_run++;
      if (seen !== exp) begin
         errors++;
         $display("unexpected %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic wait_ready();
      do begin
         @(posedge hclk);
      end while (hready !== 1'b1);
   endtask : wait_ready
   task automatic ahb(input logic w, input logic [7:0] a,
         input logic [31:0] wd, output logic [31:0] rd);
      hsel <= 1'b1;
      htrans <= pllrc_pkg::HTRANS_NONSEQ;
      haddr <= {24'h0, a};
      hwrite <= w;
      wait_ready();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      wait_ready();
      rd = hrdata;
   endtask : ahb
   task automatic wr(input logic [7:0] a, input logic [31:0] wd);
      logic [31:0] d;
      ahb(1'b1, a, wd, d);
   endtask : wr
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e,
         input string what);
      logic [31:0] d;
      ahb(1'b0, a, 32'h0, d);
      check(what, d, e);
   endtask : rd_chk
   // expected taps after one step, worked out from the select decode
   function automatic logic [17:0] next_taps(logic [17:0] t, logic [2:0] s,
         logic up);
      int i;
      for (i = 0; i < 6; i++)
         if ((s == 3'h0 && i < 5) || (s == 3'h1 && i == 5) ||
               (s >= 3'h2 && i == int'(s) - 2))
            t[i*3 +: 3] = up ? t[i*3 +: 3] + 3'h1 : t[i*3 +: 3] - 3'h1;
      return t;
   endfunction : next_taps
   // =====================================================================
   initial begin
      #400000;
      errors++;
      finish_test();
   end
   initial begin
      logic [31:0] d;
      logic [17:0] t;
      logic [143:0] c, c2;
      logic [2:0] s;
      int k;
      repeat (20) @(posedge hclk);
      hresetn <= 1'b1;
      repeat (70) @(posedge hclk);
      rd_chk(8'h04, 32'h1, "status");
      rd_chk(8'h10, 32'h00060000, "cnt0");
      wr(8'h80, 32'hFFFFFFFF);
      rd_chk(8'h80, 32'h0, "unmapped");
      wr(8'h00, 32'h0202);
      rd_chk(8'h00, 32'h0202, "ctrl");
      t = '0;
      // selects 0..6 up, then C0 down past zero; 111 is never sent
      for (k = 0; k < 10; k++) begin
         s = (k < 7) ? 3'(k) : 3'h2;
         m.phase_move(k < 7, s);
         t = next_taps(t, s, k < 7);
         check("taps", 32'(phase_taps), 32'(t));
      end
      c = '0;
      c[7:0] = 8'h01;
      c[54 +: 18] = 18'h35555;
      c[72 +: 18] = 18'h00605;
      c[126 +: 18] = 18'h0E606;
      m.shift_bits(c, 144);
      rd_chk(8'h04, 32'h9001, "shift count");
      m.update();
      rd_chk(8'h04, 32'h1, "status");
      check("scan done rises", 32'(scan_rises), 32'h1);
      rd_chk(8'h0C, 32'h00730006, "loop");
      rd_chk(8'h10, 32'h00200605, "cnt0");
      rd_chk(8'h14, 32'h00075555, "cnt1");
      rd_chk(8'h20, 32'h00040001, "cnt4");
      for (k = 0; k < 3; k++) begin
         c2 = c;
         c2[126 +: 18] = bad[k];
         c2[7:0] = 8'(k + 2);
         m.shift_bits(c2, 144);
         m.update();
         rd_chk(8'h0C, 32'h00730006, "loop kept");
         rd_chk(8'h04, 32'h5, "code error");
         wr(8'h04, 32'h4);
         rd_chk(8'h20, 32'((k + 2) << 18) | 32'(k + 2), "cnt4");
      end
      rd_chk(8'h08, {14'h0, t}, "taps");
      m.shift_bits(c, 10);
      m.update();
      ahb(1'b0, 8'h04, 32'h0, d);
      check("short update", d & 32'hF, 32'h9);
      check("scan done rises", 32'(scan_rises), 32'h4);
      finish_test();
   end
endmodule : pllrc_top_tb_top
